// ### rtl/rtccal_top.sv
// Functional notes
// - weekday is three bits, values 0 to 6
// - weekday 000 Sunday, 001 Monday for weeks
// - unimplemented calendar bits read as zero
// - month stored BCD 1 to 12
// - year stored as two BCD digits 0-99
// - value bits not touched by reset
// - counters frozen during a host access
// - one missed tick queued, applied after access
// - compare each enabled match field with time
// - second match bit 7 disables, resets 1
// - second match value BCD 0 to 59
// - minute match bit 7 disables, resets 1
// - minute match value BCD 0 to 59
// - leap year when year divisible by four
// - match flag sets on first full agreement
`timescale 1ns/1ps
`include "rtccal_regs.svh"

// one bcd digit step with carry, used per year digit
module rtccal_bcd_step #(
	parameter int WIDTH = 4
) (
	input wire logic [WIDTH-1:0] digit,
	input wire logic carry_in,
	output logic [WIDTH-1:0] digit_next,
	output logic carry_out
);
	import rtccal_pkg::*;

	always_comb
	begin
		digit_next = digit;
		carry_out = 1'b0;
		if (carry_in)
		begin
			if (digit == WIDTH'(`RTCCAL_DIGIT_NINE))
			begin
				digit_next = WIDTH'(`RTCCAL_DIGIT_ZERO);
				carry_out = 1'b1;
			end
			else
				digit_next = digit + WIDTH'(`RTCCAL_DIGIT_ONE);
		end
	end

endmodule : rtccal_bcd_step

// one match field: disable bit on top, bcd value below
module rtccal_match_field #(
	parameter int WIDTH = 7
) (
	input wire logic [WIDTH-1:0] cur,
	input wire logic [WIDTH:0] stored,
	output logic enabled,
	output logic agree
);
	import rtccal_pkg::*;

	always_comb
	begin
		enabled = !stored[WIDTH];
		agree = !enabled || (cur == stored[WIDTH-1:0]);
	end

endmodule : rtccal_match_field

module rtccal_top (
	input wire logic MCLK,
	input wire logic RST,
	input wire rtccal_pkg::rtccal_acc_t ACC,
	input wire logic TICK_1HZ,
	input wire logic [6:0] CUR_SEC,
	input wire logic [6:0] CUR_MIN,
	input wire logic DAY_CARRY,
	input wire logic MONTH_CARRY,
	input wire logic OTHER_MATCH,
	input wire logic OTHER_EN,
	input wire logic MATCH_CLR,
	output logic [7:0] RDATA,
	output logic FREEZE,
	output logic SEC_INC,
	output logic MATCH_FLAG,
	output logic [4:0] MONTH_OUT,
	output logic LEAP_YEAR,
	output logic WEEK_INC
);
	import rtccal_pkg::*;

	rtccal_state_t st_reg;
	rtccal_state_t st_next;
	logic sec_en;
	logic min_en;
	logic sec_ok;
	logic min_ok;
	logic wr_wday;
	logic wr_month;
	logic wr_year;
	logic wr_sec_match;
	logic wr_min_match;
	logic [7:0] rd_byte;
	logic [3:0] yr_units_next;
	logic [3:0] yr_tens_next;
	logic yr_carry;
	logic any_en;
	logic all_ok;
	logic hit;
	logic roll_year;

	// next BCD month, wrapping 12 to 1
	function automatic logic [4:0] month_inc(input logic [4:0] m);
		logic [4:0] r;
		r = m + 5'h01;
		if (m == `RTCCAL_MONTH_LAST)
			r = `RTCCAL_MONTH_FIRST;
		else if (m == `RTCCAL_MONTH_NINE)
			r = `RTCCAL_MONTH_TEN;
		return r;
	endfunction : month_inc

	// BCD divisible by four, year 00 included
	function automatic logic is_leap(input logic [7:0] y);
		logic r;
		if (y[4])
			r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		else
			r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		return r;
	endfunction : is_leap

	// year digits step when december rolls over, 99 wraps to 00
	rtccal_bcd_step #(
		.WIDTH(4)
	) i_year_units (
		.digit(st_reg.year[3:0]),
		.carry_in(roll_year),
		.digit_next(yr_units_next),
		.carry_out(yr_carry)
	);

	rtccal_bcd_step #(
		.WIDTH(4)
	) i_year_tens (
		.digit(st_reg.year[7:4]),
		.carry_in(yr_carry),
		.digit_next(yr_tens_next),
		.carry_out()
	);

	// second and minute fields against the running time
	rtccal_match_field #(
		.WIDTH(7)
	) i_sec_field (
		.cur(CUR_SEC),
		.stored(st_reg.sec_match),
		.enabled(sec_en),
		.agree(sec_ok)
	);

	rtccal_match_field #(
		.WIDTH(7)
	) i_min_field (
		.cur(CUR_MIN),
		.stored(st_reg.min_match),
		.enabled(min_en),
		.agree(min_ok)
	);

	// write decode, unmapped locations select nothing
	always_comb
	begin
		wr_wday = ACC.wr && (ACC.addr == `RTCCAL_ADDR_WEEKDAY);
		wr_month = ACC.wr && (ACC.addr == `RTCCAL_ADDR_MONTH);
		wr_year = ACC.wr && (ACC.addr == `RTCCAL_ADDR_YEAR);
		wr_sec_match = ACC.wr && (ACC.addr == `RTCCAL_ADDR_SEC_MATCH);
		wr_min_match = ACC.wr && (ACC.addr == `RTCCAL_ADDR_MIN_MATCH);
	end

	// read mux: unused bits and unmapped locations give zero
	always_comb
	begin
		rd_byte = 8'h00;
		case (ACC.addr)
			`RTCCAL_ADDR_WEEKDAY:
				rd_byte = {5'h00, st_reg.wday};
			`RTCCAL_ADDR_MONTH:
				rd_byte = {3'h0, st_reg.month};
			`RTCCAL_ADDR_YEAR:
				rd_byte = st_reg.year;
			`RTCCAL_ADDR_SEC_MATCH:
				rd_byte = st_reg.sec_match;
			`RTCCAL_ADDR_MIN_MATCH:
				rd_byte = st_reg.min_match;
			default:
				rd_byte = 8'h00;
		endcase
	end

	// match comparison on the time after an increment
	always_comb
	begin
		any_en = sec_en || min_en || OTHER_EN;
		all_ok = OTHER_MATCH && sec_ok && min_ok;
		hit = st_reg.chk && any_en && all_ok;
		roll_year = MONTH_CARRY && !st_reg.freeze
			&& (st_reg.month == `RTCCAL_MONTH_LAST);
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.sec_inc = 1'b0;
		st_next.week_inc = 1'b0;
		st_next.freeze = ACC.act;
		if (st_reg.freeze)
		begin
			if (TICK_1HZ)
				st_next.pend = 1'b1;
		end
		else if (TICK_1HZ || st_reg.pend)
		begin
			st_next.sec_inc = 1'b1;
			st_next.pend = 1'b0;
		end
		// compare one cycle after the seconds counter moves
		st_next.chk = st_reg.sec_inc;
		if (hit)
			st_next.flag = 1'b1;
		else if (MATCH_CLR)
			st_next.flag = 1'b0;
		if (DAY_CARRY && !st_reg.freeze)
		begin
			if (st_reg.wday >= `RTCCAL_WDAY_LAST)
				st_next.wday = `RTCCAL_WDAY_FIRST;
			else
				st_next.wday = st_reg.wday + 3'h1;
			st_next.week_inc = (st_reg.wday >= `RTCCAL_WDAY_LAST);
		end
		if (MONTH_CARRY && !st_reg.freeze)
			st_next.month = month_inc(st_reg.month);
		if (roll_year)
			st_next.year = {yr_tens_next, yr_units_next};
		// host writes land only in implemented bits; a write beats a carry
		// three-bit weekday
		if (wr_wday)
			st_next.wday = ACC.wdata[`RTCCAL_WDAY_MSB:0];
		if (wr_month)
			st_next.month = ACC.wdata[`RTCCAL_MONTH_MSB:0];
		if (wr_year)
			st_next.year = ACC.wdata;
		if (wr_sec_match)
			st_next.sec_match = ACC.wdata;
		if (wr_min_match)
			st_next.min_match = ACC.wdata;
		st_next.leap = is_leap(st_next.year);
		// read data holds until the next read strobe
		st_next.rdata = st_reg.rdata;
		if (ACC.rd)
			st_next.rdata = rd_byte;
	end

	// value bits keep their contents through reset
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			st_reg.sec_match[`RTCCAL_MATCH_DIS_BIT] <= `RTCCAL_MATCH_DIS_RST;
			st_reg.min_match[`RTCCAL_MATCH_DIS_BIT] <= `RTCCAL_MATCH_DIS_RST;
			st_reg.freeze <= 1'b0;
			st_reg.pend <= 1'b0;
			st_reg.sec_inc <= 1'b0;
			st_reg.chk <= 1'b0;
			st_reg.flag <= 1'b0;
			st_reg.week_inc <= 1'b0;
			st_reg.rdata <= 8'h00;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign RDATA = st_reg.rdata;
	assign FREEZE = st_reg.freeze;
	assign SEC_INC = st_reg.sec_inc;
	assign MATCH_FLAG = st_reg.flag;
	assign MONTH_OUT = st_reg.month;
	assign LEAP_YEAR = st_reg.leap;
	assign WEEK_INC = st_reg.week_inc;

endmodule : rtccal_top

// ### include/rtccal_regs.svh
`ifndef RTCCAL_REGS_SVH
`define RTCCAL_REGS_SVH

// register locations
`define RTCCAL_ADDR_WEEKDAY 8'h07
`define RTCCAL_ADDR_MONTH 8'h08
`define RTCCAL_ADDR_YEAR 8'h09
`define RTCCAL_ADDR_SEC_MATCH 8'h0a
`define RTCCAL_ADDR_MIN_MATCH 8'h0b

// field layout
`define RTCCAL_WDAY_MSB 2
`define RTCCAL_MONTH_MSB 4
`define RTCCAL_MATCH_DIS_BIT 7
`define RTCCAL_MATCH_VAL_MSB 6

// reset value of a match disable bit
`define RTCCAL_MATCH_DIS_RST 1'b1

// counting limits
`define RTCCAL_WDAY_FIRST 3'h0
`define RTCCAL_WDAY_LAST 3'h6
`define RTCCAL_MONTH_FIRST 5'h01
`define RTCCAL_MONTH_LAST 5'h12
`define RTCCAL_MONTH_NINE 5'h09
`define RTCCAL_MONTH_TEN 5'h10
`define RTCCAL_DIGIT_NINE 4'h9
`define RTCCAL_DIGIT_ZERO 4'h0
`define RTCCAL_DIGIT_ONE 4'h1

`endif

// ### include/rtccal_pkg.sv
package rtccal_pkg;

	// one register access from the serial front end
	typedef struct packed {
		logic act;
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtccal_acc_t;

	typedef struct packed {
		logic [2:0] wday;
		logic [4:0] month;
		logic [7:0] year;
		logic [7:0] sec_match;
		logic [7:0] min_match;
		logic leap;
		logic freeze;
		logic pend;
		logic sec_inc;
		logic chk;
		logic flag;
		logic week_inc;
		logic [7:0] rdata;
	} rtccal_state_t;

endpackage : rtccal_pkg

// ### sim/rtccal_asserts.sv
`timescale 1ns/1ps
module rtccal_asserts (
	input wire logic MCLK,
	input wire logic RST,
	input wire rtccal_pkg::rtccal_acc_t ACC,
	input wire logic TICK_1HZ,
	input wire logic [6:0] CUR_SEC,
	input wire logic DAY_CARRY,
	input wire logic MONTH_CARRY,
	input wire logic OTHER_MATCH,
	input wire logic MATCH_CLR,
	input wire logic FREEZE,
	input wire logic SEC_INC,
	input wire logic MATCH_FLAG,
	input wire logic [4:0] MONTH_OUT,
	input wire logic WEEK_INC
);
	import rtccal_pkg::*;
	logic [7:0] sm_reg, mm_reg;
	logic pend_reg, hit;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// sufficient for a set: second enabled and equal, minute disabled, other fields matching
	assign hit = !sm_reg[7] && sm_reg[6:0] == CUR_SEC && mm_reg[7] && OTHER_MATCH;
	always_ff @(posedge MCLK or posedge RST)
		if (RST)
			{sm_reg[7], mm_reg[7], pend_reg} <= 3'h6;
		else
		begin
			pend_reg <= FREEZE & (pend_reg | TICK_1HZ);
			sm_reg <= (ACC.wr && ACC.addr == 8'h0a) ? ACC.wdata : sm_reg;
			mm_reg <= (ACC.wr && ACC.addr == 8'h0b) ? ACC.wdata : mm_reg;
		end
	a_tick_inc: assert property (TICK_1HZ && !FREEZE |=> SEC_INC) else $error("tick lost");
	a_freeze_hold: assert property (FREEZE |=> !SEC_INC) else $error("step when frozen");
	a_pend_apply: assert property (pend_reg && !FREEZE |=> SEC_INC) else $error("queue lost");
	a_flag_set: assert property (SEC_INC ##1 hit |=> MATCH_FLAG) else $error("no flag");
	a_flag_cause: assert property ($rose(MATCH_FLAG) |-> $past(SEC_INC, 2))
		else $error("flag without step");
	a_flag_clr: assert property (MATCH_CLR && !$past(SEC_INC) |=> !MATCH_FLAG)
		else $error("flag not cleared");
	a_week_wrap: assert property (WEEK_INC |-> $past(DAY_CARRY && !FREEZE))
		else $error("week pulse without day");
	a_year_roll: assert property (MONTH_CARRY && !FREEZE && MONTH_OUT == 5'h12
		|=> MONTH_OUT == 5'h01) else $error("month not wrapped");
	c_pend: cover property (pend_reg && !FREEZE);
	c_year: cover property (MONTH_CARRY && !FREEZE && MONTH_OUT == 5'h12);
	c_flag: cover property ($rose(MATCH_FLAG));
	c_week: cover property (WEEK_INC);
endmodule : rtccal_asserts

bind rtccal_top rtccal_asserts i_chk (.*);

// ### sim/rtccal_sec_model.sv
`timescale 1ns/1ps
module rtccal_sec_model (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SEC_INC,
	output logic [6:0] CUR_SEC
);
	// bcd seconds counter stepped by each increment pulse
	always_ff @(posedge MCLK or posedge RST)
		if (RST)
			CUR_SEC <= 7'h58;
		else if (SEC_INC)
			CUR_SEC <= CUR_SEC == 7'h59 ? 7'h00 : CUR_SEC + (CUR_SEC[3:0] == 4'h9 ? 7'h07 : 7'h01);
endmodule : rtccal_sec_model

// ### sim/rtccal_top_tb.sv
`timescale 1ns/1ps
module rtccal_top_tb;
	import rtccal_pkg::*;
	logic MCLK = 0, RST = 1, TICK_1HZ = 0, DAY_CARRY = 0, MONTH_CARRY = 0, MATCH_CLR = 0;
	logic OTHER_MATCH = 1, OTHER_EN = 0, FREEZE, SEC_INC, MATCH_FLAG, LEAP_YEAR, WEEK_INC;
	rtccal_acc_t ACC = '0;
	logic [6:0] CUR_SEC, CUR_MIN = 7'h00;
	logic [4:0] MONTH_OUT;
	logic [7:0] RDATA, v, incs = 0, wk = 0;
	logic [7:0] mk [6] = '{8'h07, 8'h1f, 8'hff, 8'hff, 8'hff, 8'h00};
	logic [31:0] tv [3] = '{32'h12990100, 32'h09041004, 32'h12020103};
	int errors = 0, compares = 0, seed = 2800, n;
	rtccal_top i_dut (.*);
	rtccal_sec_model i_far (.*);
	always #2.5 MCLK = ~MCLK;
	always @(posedge MCLK)
	begin
		incs <= incs + 8'(SEC_INC);
		wk <= wk + 8'(WEEK_INC);
	end
	// expected leap bit: a ten counts 2 modulo 4
	function automatic logic [7:0] exp_leap(input logic [7:0] y);
		return 8'((y[3:0] + 4'(y[4]) * 4'h2) % 4'h4 == 4'h0);
	endfunction : exp_leap
	task chk(input logic [7:0] s, e, input string nm);
		compares++;
		if (s !== e)
			$display("CHECK FAILED %s exp %h seen %h", nm, e, s);
		errors += int'(s !== e);
	endtask : chk
	// a read compares the returned byte with d
	task acc(input logic w, input logic [7:0] a, d);
		ACC <= '{1'b1, w, !w, a, w ? d : 8'h00};
		@(posedge MCLK);
		ACC <= '0;
		@(posedge MCLK);
		if (!w)
			chk(RDATA, d, "rdata");
	endtask : acc
	// one-cycle pulse: 0 tick, 1 day carry, 2 month carry, 3 flag clear
	task automatic pulse(input int k);
		TICK_1HZ <= (k == 0);
		DAY_CARRY <= (k == 1);
		MONTH_CARRY <= (k == 2);
		MATCH_CLR <= (k == 3);
		@(posedge MCLK);
		{TICK_1HZ, DAY_CARRY, MONTH_CARRY, MATCH_CLR} <= 4'h0;
		repeat (3) @(posedge MCLK);
	endtask : pulse
	task conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (6) @(posedge MCLK);
		RST <= 1'b0;
		repeat (24)
		begin
			n = {$random(seed)} % 6;
			v = 8'($random(seed));
			acc(1'b1, 8'(n + 7), v);
			acc(1'b0, 8'(n + 7), v & mk[n]);
		end
		acc(1'b1, 8'h0a, 8'h00);
		acc(1'b1, 8'h0b, 8'h80);
		v = incs;
		ACC.act <= 1'b1;
		@(posedge MCLK);
		pulse(0);
		pulse(0);
		chk(incs - v, 8'h00, "frozen");
		// access spans two ticks, only one is queued
		ACC.act <= 1'b0;
		repeat (4) @(posedge MCLK);
		chk(incs - v, 8'h01, "queued");
		acc(1'b1, 8'h07, 8'h06);
		v = wk;
		pulse(1);
		acc(1'b0, 8'h07, 8'h00);
		pulse(1);
		acc(1'b0, 8'h07, 8'h01);
		chk(wk - v, 8'h01, "week");
		foreach (tv[i])
		begin
			// month and year set back to back
			acc(1'b1, 8'h08, tv[i][31:24]);
			acc(1'b1, 8'h09, tv[i][23:16]);
			pulse(2);
			chk({3'h0, MONTH_OUT}, tv[i][15:8], "month out");
			acc(1'b0, 8'h08, tv[i][15:8]);
			acc(1'b0, 8'h09, tv[i][7:0]);
			chk(8'(LEAP_YEAR), exp_leap(tv[i][7:0]), "leap");
		end
		pulse(3);
		for (n = 0; n < 70 && MATCH_FLAG !== 1'b1; n++)
			pulse(0);
		chk(8'(MATCH_FLAG), 8'h01, "flag");
		pulse(0);
		chk({MATCH_FLAG, CUR_SEC}, 8'h81, "sticky");
		pulse(3);
		pulse(0);
		chk(8'(MATCH_FLAG), 8'h00, "cleared");
		acc(1'b1, 8'h09, 8'h37);
		acc(1'b1, 8'h0b, 8'h05);
		RST <= 1'b1;
		repeat (2) @(posedge MCLK);
		RST <= 1'b0;
		acc(1'b0, 8'h09, 8'h37);
		acc(1'b0, 8'h0a, 8'h80);
		acc(1'b0, 8'h0b, 8'h85);
		conclude;
	end
endmodule : rtccal_top_tb
